// ### verilog/mprc_top.sv
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`include "mprc_cfg.svh"

module mprc_top
    import mprc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // program fetcher
    input wire logic blk_valid,
    input wire logic [2:0] blk_kind,
    input wire logic [`MPRC_MCW-1:0] blk_mcode,
    output logic blk_accept,
    output logic blk_skip,
    // axes and task
    input wire logic motion_done,
    input wire logic task_err_evt,
    input wire logic opt_in,
    output logic motion_run,
    output logic decel_req,
    output logic jog_run,
    output logic org_busy,
    // flags
    output logic [`MPRC_MCW-1:0] mcode_out,
    output logic manual_flag,
    output logic prog_run,
    output logic task_err
);

    mprc_state_t s_r;
    mprc_state_t n;
    logic [`MPRC_NSMP-1:0] rise;
    logic [`MPRC_NSMP-1:0] fall;
    logic [`MPRC_NCTL-1:0] ctl;
    logic [31:0] stat;
    logic strt;
    logic terr;
    logic go;
    logic done;

    assign ctl = s_r.ctrl;

    // ****************************************
    // control bit transitions
    // ****************************************
    mprc_edge u_edge (
        .hclk(hclk),
        .hresetn(hresetn),
        .smp({opt_in, s_r.ctrl}),
        .rise(rise),
        .fall(fall)
    );

    // status word seen by software
    always_comb begin
        stat = 32'h0000_0000;
        stat[`MPRC_S_RUN] = s_r.st == ST_RUN;
        stat[`MPRC_S_PAUSE] = s_r.st == ST_PAUSE;
        stat[`MPRC_S_STOP] = s_r.st == ST_STOP;
        stat[`MPRC_S_MAN] = s_r.manual;
        stat[`MPRC_S_DECEL] = s_r.decel;
        stat[`MPRC_S_TERR] = s_r.terr;
        stat[`MPRC_S_MWAIT] = s_r.blk_act && s_r.kind == `MPRC_K_MCODE;
        stat[`MPRC_S_ORG] = s_r.org_busy;
        stat[`MPRC_S_JOG] = s_r.jog_run;
        stat[`MPRC_S_SKIP] = s_r.skip_nxt;
        stat[`MPRC_S_OEND] = s_r.after_oend;
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        n = s_r;
        n.accept = 1'b0;
        n.skip = 1'b0;
        done = 1'b0;
        // bus: zero wait, read data captured in the address phase;
        // a write lands at the end of its data phase
        strt = hsel && hready && htrans[1] && hsize == `MPRC_HSIZE_W;
        if (s_r.wr_pend && s_r.waddr == `MPRC_OFS_CTRL) begin
            n.ctrl = hwdata[`MPRC_NCTL-1:0];
        end
        n.wr_pend = strt && hwrite;
        n.waddr = haddr[7:0];
        if (strt && !hwrite) begin
            unique case (haddr[7:0])
                `MPRC_OFS_CTRL: n.hrdata = {24'h00_0000, s_r.ctrl};
                `MPRC_OFS_STAT: n.hrdata = stat;
                `MPRC_OFS_MCODE: n.hrdata = {24'h00_0000, s_r.mcode};
                default: n.hrdata = 32'h0000_0000;
            endcase
        end
        // error flag: a new error wins over a same-cycle reset
        terr = s_r.terr;
        if (rise[`MPRC_B_TRST]) begin
            terr = 1'b0;
        end
        if (task_err_evt) begin
            terr = 1'b1;
        end
        n.terr = terr;
        // start needs a fresh rise with no pause, no forced end, no error
        go = rise[`MPRC_B_CYC] && ctl[`MPRC_B_AUTO] && !ctl[`MPRC_B_PAUSE]
            && !ctl[`MPRC_B_FEND] && !terr;
        unique case (s_r.st)
            ST_IDLE, ST_STOP, ST_PAUSE: begin
                // a held block resumes where it was, M code included
                if (!ctl[`MPRC_B_AUTO]) begin
                    n.st = ST_DECEL;
                    n.blk_act = 1'b0;
                    n.after_oend = 1'b0;
                end else if (go) begin
                    n.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!ctl[`MPRC_B_AUTO]) begin
                    // stop the program, axes ramp down, M code stays
                    n.st = ST_DECEL;
                    n.blk_act = 1'b0;
                    n.after_oend = 1'b0;
                end else if (task_err_evt) begin
                    n.st = ST_STOP;
                    n.blk_act = 1'b0;
                end else if (rise[`MPRC_B_FEND]) begin
                    // cancel block; optional input and M code reset lose
                    n.st = ST_STOP;
                    n.blk_act = 1'b0;
                    n.mcode = '0;
                    n.after_oend = 1'b0;
                    n.skip_nxt = 1'b0;
                end else if (rise[`MPRC_B_PAUSE]) begin
                    // block held as is, optional input not looked at
                    n.st = ST_PAUSE;
                end else if (!s_r.blk_act) begin
                    // wait one cycle after an accept for the next block
                    if (blk_valid && !s_r.accept) begin
                        n.accept = 1'b1;
                        if (s_r.skip_nxt) begin
                            n.skip = 1'b1;
                            n.skip_nxt = 1'b0;
                        end else begin
                            n.blk_act = 1'b1;
                            n.kind = blk_kind;
                            if (blk_kind == `MPRC_K_MCODE) begin
                                // reset already on: no M code output
                                if (ctl[`MPRC_B_MRST]) begin
                                    n.blk_act = 1'b0;
                                    n.after_oend = 1'b0;
                                end else begin
                                    n.mcode = blk_mcode;
                                end
                            end
                        end
                    end
                end else begin
                    unique case (s_r.kind)
                        `MPRC_K_MCODE: begin
                            if (s_r.after_oend && rise[`MPRC_B_OPT]) begin
                                n.mcode = '0;
                                done = 1'b1;
                            end else if (fall[`MPRC_B_MRST]) begin
                                n.mcode = '0;
                                done = 1'b1;
                            end
                        end
                        `MPRC_K_SKIP: begin
                            n.skip_nxt = opt_in;
                            done = 1'b1;
                        end
                        `MPRC_K_PSTOP: begin
                            if (opt_in) begin
                                n.st = ST_STOP;
                            end
                            done = 1'b1;
                        end
                        `MPRC_K_OEND: begin
                            n.blk_act = 1'b0;
                            n.after_oend = 1'b1;
                        end
                        default: begin
                            // motion or dwell; input may cut it short
                            if (s_r.after_oend && rise[`MPRC_B_OPT]) begin
                                done = 1'b1;
                            end else if (motion_done) begin
                                done = 1'b1;
                            end
                        end
                    endcase
                    if (done) begin
                        n.blk_act = 1'b0;
                        n.after_oend = 1'b0;
                    end
                end
            end
            ST_DECEL: begin
                // no jog until the axes have settled
                if (motion_done) begin
                    n.st = ST_MAN;
                end
            end
            ST_MAN: begin
                if (ctl[`MPRC_B_AUTO]) begin
                    n.st = ST_IDLE;
                    n.org_busy = 1'b0;
                end else if (rise[`MPRC_B_ORG]) begin
                    n.org_busy = 1'b1;
                end else if (motion_done) begin
                    n.org_busy = 1'b0;
                end
            end
            default: begin
                n.st = ST_IDLE;
            end
        endcase
        // registered outputs follow the next state
        n.prog_run = n.st == ST_RUN;
        n.motion_run = n.st == ST_RUN && n.blk_act
            && (n.kind == `MPRC_K_MOVE || n.kind == `MPRC_K_DWELL);
        n.decel = n.st == ST_DECEL;
        n.manual = n.st == ST_MAN;
        n.jog_run = n.st == ST_MAN && ctl[`MPRC_B_JOG] && !n.org_busy;
        n.hready = 1'b1;
        n.hresp = 1'b0;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.ctrl <= `MPRC_CTRL_RST;
            s_r.hready <= 1'b1;
        end else begin
            s_r <= n;
        end
    end

    // every output straight from the state register
    assign hrdata = s_r.hrdata;
    assign hreadyout = s_r.hready;
    assign hresp = s_r.hresp;
    assign blk_accept = s_r.accept;
    assign blk_skip = s_r.skip;
    assign motion_run = s_r.motion_run;
    assign decel_req = s_r.decel;
    assign jog_run = s_r.jog_run;
    assign org_busy = s_r.org_busy;
    assign mcode_out = s_r.mcode;
    assign manual_flag = s_r.manual;
    assign prog_run = s_r.prog_run;
    assign task_err = s_r.terr;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic calm;
    assign calm = ctl[`MPRC_B_AUTO] && !task_err_evt
        && !rise[`MPRC_B_FEND] && !rise[`MPRC_B_PAUSE];

    property p_mode_keep;
        s_r.st == ST_RUN && !ctl[`MPRC_B_AUTO] |=> $stable(mcode_out)
            ##1 $stable(mcode_out);
    endproperty
    a_mode_keep: assert property (p_mode_keep)
        else $error("m code changed on switch to manual");
    property p_pause_mrst;
        s_r.st == ST_PAUSE && fall[`MPRC_B_MRST] |=> $stable(mcode_out);
    endproperty
    a_pause_mrst: assert property (p_pause_mrst)
        else $error("m code reset acted while paused");
    property p_pause_wins;
        s_r.st == ST_RUN && rise[`MPRC_B_PAUSE] && ctl[`MPRC_B_AUTO]
            && !task_err_evt && !rise[`MPRC_B_FEND]
            |=> s_r.st == ST_PAUSE && $stable(mcode_out);
    endproperty
    a_pause_wins: assert property (p_pause_wins)
        else $error("pause did not hold m code");
    property p_fend_mwait;
        s_r.st == ST_RUN && s_r.blk_act && s_r.kind == `MPRC_K_MCODE
            && rise[`MPRC_B_FEND] && ctl[`MPRC_B_AUTO] && !task_err_evt
            |=> s_r.st == ST_STOP && !s_r.blk_act && mcode_out == '0;
    endproperty
    a_fend_mwait: assert property (p_fend_mwait)
        else $error("forced end did not cancel m code wait");
    property p_terr_start;
        s_r.st == ST_STOP && s_r.terr && rise[`MPRC_B_TRST]
            && rise[`MPRC_B_CYC] && ctl[`MPRC_B_AUTO]
            && !ctl[`MPRC_B_PAUSE] && !ctl[`MPRC_B_FEND] && !task_err_evt
            |=> !task_err && prog_run;
    endproperty
    a_terr_start: assert property (p_terr_start)
        else $error("error reset with start did not restart");
    // only settled axes may end the ramp, so the flag cannot rise early
    property p_decel_flag;
        decel_req && !motion_done |=> decel_req && !manual_flag && !jog_run;
    endproperty
    a_decel_flag: assert property (p_decel_flag)
        else $error("manual flag or jog during deceleration");
    property p_man_after;
        s_r.st == ST_DECEL && motion_done |=> manual_flag && !decel_req;
    endproperty
    a_man_after: assert property (p_man_after)
        else $error("manual flag late after deceleration");
    property p_org_auto;
        s_r.st == ST_MAN && ctl[`MPRC_B_AUTO] |=> !org_busy && !manual_flag;
    endproperty
    a_org_auto: assert property (p_org_auto)
        else $error("busy stayed on entering automatic");
    property p_skip_set;
        s_r.st == ST_RUN && s_r.blk_act && s_r.kind == `MPRC_K_SKIP
            && opt_in && calm |=> s_r.skip_nxt;
    endproperty
    a_skip_set: assert property (p_skip_set)
        else $error("optional skip not armed");
    property p_fend_start;
        rise[`MPRC_B_CYC] && ctl[`MPRC_B_FEND] |=> !prog_run;
    endproperty
    a_fend_start: assert property (p_fend_start)
        else $error("program started under forced end");

    c_skip: cover property (blk_skip);
    c_pause: cover property (s_r.st == ST_PAUSE && mcode_out != '0);
    c_manual: cover property (decel_req ##1 manual_flag);

endmodule : mprc_top

// ### verilog/mprc_cfg.svh
`ifndef MPRC_CFG_SVH
`define MPRC_CFG_SVH

// ****************************************
// register map (byte addresses, low 8 bits)
// ****************************************
`define MPRC_OFS_CTRL 8'h00
`define MPRC_OFS_STAT 8'h04
`define MPRC_OFS_MCODE 8'h08
`define MPRC_HSIZE_W 3'h2

// ****************************************
// control word bits, also edge-detector index; index 8 is the optional input, not a control bit
// ****************************************
`define MPRC_B_CYC 0
`define MPRC_B_PAUSE 1
`define MPRC_B_FEND 2
`define MPRC_B_AUTO 3
`define MPRC_B_MRST 4
`define MPRC_B_TRST 5
`define MPRC_B_JOG 6
`define MPRC_B_ORG 7
`define MPRC_B_OPT 8
`define MPRC_NCTL 8
`define MPRC_NSMP 9
`define MPRC_CTRL_RST 8'h08

// ****************************************
// status word bits
// ****************************************
`define MPRC_S_RUN 0
`define MPRC_S_PAUSE 1
`define MPRC_S_STOP 2
`define MPRC_S_MAN 3
`define MPRC_S_DECEL 4
`define MPRC_S_TERR 5
`define MPRC_S_MWAIT 6
`define MPRC_S_ORG 7
`define MPRC_S_JOG 8
`define MPRC_S_SKIP 9
`define MPRC_S_OEND 10

// ****************************************
// block kinds from the program fetcher
// ****************************************
`define MPRC_K_MOVE 3'h0
`define MPRC_K_DWELL 3'h1
`define MPRC_K_MCODE 3'h2
`define MPRC_K_SKIP 3'h3
`define MPRC_K_PSTOP 3'h4
`define MPRC_K_OEND 3'h5
`define MPRC_MCW 8

`endif

// ### verilog/mprc_pkg.sv
`include "mprc_cfg.svh"

package mprc_pkg;

    // run-control states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RUN,
        ST_PAUSE,
        ST_STOP,
        ST_DECEL,
        ST_MAN
    } mprc_st_t;

    // whole state of the run-control top
    typedef struct packed {
        mprc_st_t st;
        logic [`MPRC_NCTL-1:0] ctrl;
        logic blk_act;
        logic [2:0] kind;
        logic after_oend;
        logic skip_nxt;
        logic terr;
        logic [`MPRC_MCW-1:0] mcode;
        logic wr_pend;
        logic [7:0] waddr;
        logic [31:0] hrdata;
        logic hready;
        logic hresp;
        logic accept;
        logic skip;
        logic motion_run;
        logic decel;
        logic manual;
        logic jog_run;
        logic org_busy;
        logic prog_run;
    } mprc_state_t;

    // state of the edge detector
    typedef struct packed {
        logic [`MPRC_NSMP-1:0] prev;
    } mprc_edge_t;

endpackage : mprc_pkg

// ### verilog/mprc_edge.sv
`timescale 1ns/100ps
`include "mprc_cfg.svh"

module mprc_edge
    import mprc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bits sampled this evaluation cycle
    input wire logic [`MPRC_NSMP-1:0] smp,
    // transitions against the previous sample
    output logic [`MPRC_NSMP-1:0] rise,
    output logic [`MPRC_NSMP-1:0] fall
);

    mprc_edge_t s_r;
    mprc_edge_t s_nxt;

    // one compare per bit, all bits in the same cycle
    genvar i;
    generate
        for (i = 0; i < `MPRC_NSMP; i = i + 1) begin : g_bit
            assign rise[i] = smp[i] & ~s_r.prev[i];
            assign fall[i] = ~smp[i] & s_r.prev[i];
        end
    endgenerate

    // previous sample is taken once per clock
    always_comb begin
        s_nxt = s_r;
        s_nxt.prev = smp;
    end

    // reset to the control word reset value, so no false edge on a control bit at release
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r.prev <= {1'b0, `MPRC_CTRL_RST};
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule : mprc_edge

// ### bench/mprc_fetch_model.sv
`timescale 1ns/100ps
`include "mprc_cfg.svh"

// ****************************************
// program fetcher and axis stand-in
// ****************************************
module mprc_fetch_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // block handshake
    input wire logic blk_accept,
    output logic blk_valid,
    output logic [2:0] blk_kind,
    output logic [7:0] blk_mcode,
    // axis side
    input wire logic busy,
    input wire logic hold,
    output logic motion_done
);
    logic [2:0] k_r [4];
    logic [7:0] m_r;
    logic [2:0] len_r, idx_r, cnt_r, tg_r;

    // bench fills the table; fetch restarts at block 0
    task load(input logic [11:0] k, input logic [7:0] m,
              input logic [2:0] n);
        for (int i = 0; i < 4; i++) k_r[i] <= k[3*i+:3];
        m_r <= m;
        idx_r <= 3'h0;
        len_r <= n;
    endtask : load

    // advance after each accept; hold stalls the axes for as long as it is set
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idx_r <= 3'h0;
            len_r <= 3'h0;
            cnt_r <= 3'h0;
            tg_r <= 3'h0;
            motion_done <= 1'b0;
        end else begin
            tg_r <= tg_r + 3'h1;
            motion_done <= 1'b0;
            if (blk_accept) idx_r <= idx_r + 3'h1;
            if (busy && !hold && !motion_done) begin
                cnt_r <= cnt_r + 3'h1;
                if (cnt_r == 3'h4) begin
                    cnt_r <= 3'h0;
                    motion_done <= 1'b1;
                end
            end
        end
    end

    // idle fields move every cycle so stale values are never trusted
    assign blk_valid = idx_r < len_r;
    assign blk_kind = blk_valid ? k_r[idx_r[1:0]] : tg_r;
    assign blk_mcode = blk_valid ? m_r : {tg_r, 5'h15};
endmodule : mprc_fetch_model

// ### bench/tb_motion_program_run_control.sv
`timescale 1ns/100ps
`include "mprc_cfg.svh"

module tb_motion_program_run_control;
    import mprc_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = `MPRC_HSIZE_W;
    logic hready, hreadyout, hresp, blk_valid, blk_accept, blk_skip;
    logic [2:0] blk_kind;
    logic [7:0] blk_mcode, mcode_out;
    logic motion_done, task_err_evt = 1'b0, opt_in = 1'b0, hold = 1'b1;
    logic motion_run, decel_req, jog_run, org_busy;
    logic manual_flag, prog_run, task_err;
    int mismatches = 0, checks_done = 0, n_acc = 0, n_skip = 0, a0;

    always #25 hclk = ~hclk;
    assign hready = hreadyout;

    mprc_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .blk_valid(blk_valid),
        .blk_kind(blk_kind), .blk_mcode(blk_mcode),
        .blk_accept(blk_accept), .blk_skip(blk_skip),
        .motion_done(motion_done), .task_err_evt(task_err_evt),
        .opt_in(opt_in), .motion_run(motion_run), .decel_req(decel_req),
        .jog_run(jog_run), .org_busy(org_busy), .mcode_out(mcode_out),
        .manual_flag(manual_flag), .prog_run(prog_run),
        .task_err(task_err));

    mprc_fetch_model u_fetch (.hclk(hclk), .hresetn(hresetn),
        .blk_accept(blk_accept), .blk_valid(blk_valid),
        .blk_kind(blk_kind), .blk_mcode(blk_mcode),
        .busy(motion_run | decel_req | org_busy), .hold(hold),
        .motion_done(motion_done));

    // block traffic counters
    always @(posedge hclk) begin
        if (blk_accept === 1'b1) n_acc++;
        if ((blk_accept & blk_skip) === 1'b1) n_skip++;
    end

    // ****************************************
    // shared tasks
    // ****************************************
    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : print_verdict

    task chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR t=%0t seen %h exp %h", $time, s, e);
        end
    endtask : chk

    // one single ahb transfer; waits are bounded
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        rd = hrdata;
        if (n >= 100) begin
            mismatches++;
            print_verdict();
        end
    endtask : ahb

    // write control word, then let the edge act and outputs settle
    task wctl(input logic [7:0] v);
        ahb(1'b1, `MPRC_OFS_CTRL, {24'h0, v});
        repeat (3) @(posedge hclk);
    endtask : wctl

    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        ahb(1'b0, `MPRC_OFS_CTRL, 32'h0);
        chk(rd, 32'h8);
        ahb(1'b0, 8'h0C, 32'h0);
        chk(rd, 32'h0);
        chk(hreadyout, 1'b1);
        chk(hresp, 1'b0);
    endtask : t_reset

    task t_mcode;
        u_fetch.load(12'h002, 8'h5A, 3'h2);
        wctl(8'h08);
        wctl(8'h09);
        chk(mcode_out, 8'h5A);
        ahb(1'b0, `MPRC_OFS_MCODE, 32'h0);
        chk(rd, 32'h5A);
        wctl(8'h1B);
        chk({prog_run, mcode_out}, 9'h05A);
        wctl(8'h0A);
        chk(mcode_out, 8'h5A);
        wctl(8'h19);
        chk({prog_run, mcode_out}, 9'h15A);
        a0 = n_acc;
        wctl(8'h0D);
        chk({prog_run, mcode_out}, 9'h000);
        chk(n_acc - a0, 0);
        wctl(8'h08);
    endtask : t_mcode

    task t_terr;
        u_fetch.load(12'h000, 8'h00, 3'h1);
        wctl(8'h09);
        @(posedge hclk) task_err_evt <= 1'b1;
        @(posedge hclk) task_err_evt <= 1'b0;
        repeat (3) @(posedge hclk);
        chk({task_err, prog_run}, 2'h2);
        wctl(8'h08);
        wctl(8'h29);
        chk({task_err, prog_run}, 2'h1);
    endtask : t_terr

    task t_manual;
        u_fetch.load(12'h000, 8'h00, 3'h1);
        repeat (4) @(posedge hclk);
        chk(motion_run, 1'b1);
        wctl(8'h01);
        chk({decel_req, manual_flag}, 2'h2);
        wctl(8'h41);
        chk(jog_run, 1'b0);
        hold <= 1'b0;
        repeat (12) @(posedge hclk);
        chk({manual_flag, jog_run}, 2'h3);
        hold <= 1'b1;
        wctl(8'h80);
        chk(org_busy, 1'b1);
        wctl(8'h88);
        chk({org_busy, manual_flag}, 2'h0);
        hold <= 1'b0;
        repeat (12) @(posedge hclk);
    endtask : t_manual

    task t_start_fend;
        wctl(8'h08);
        wctl(8'h0D);
        chk(prog_run, 1'b0);
        wctl(8'h08);
    endtask : t_start_fend

    task t_skip_stop;
        opt_in <= 1'b1;
        u_fetch.load(12'h003, 8'h00, 3'h3);
        a0 = n_skip;
        wctl(8'h09);
        repeat (40) @(posedge hclk);
        chk(n_skip - a0, 1);
        a0 = n_acc;
        u_fetch.load(12'h004, 8'h00, 3'h2);
        repeat (10) @(posedge hclk);
        chk(prog_run, 1'b0);
        chk(n_acc - a0, 1);
        ahb(1'b0, `MPRC_OFS_STAT, 32'h0);
        chk(rd[`MPRC_S_STOP], 1'b1);
        opt_in <= 1'b0;
    endtask : t_skip_stop

    // optional end before an M code and another before a dwell, both cut by the input
    task t_oend;
        hold <= 1'b1;
        wctl(8'h08);
        u_fetch.load(12'h355, 8'h33, 3'h4);
        wctl(8'h09);
        repeat (3) @(posedge hclk);
        chk(mcode_out, 8'h33);
        a0 = n_acc;
        opt_in <= 1'b1;
        repeat (6) @(posedge hclk);
        chk(mcode_out, 8'h00);
        chk(n_acc - a0, 2);
        chk(motion_run, 1'b1);
        opt_in <= 1'b0;
        @(posedge hclk) opt_in <= 1'b1;
        repeat (3) @(posedge hclk);
        chk({prog_run, motion_run}, 2'h2);
        opt_in <= 1'b0;
    endtask : t_oend

    // ****************************************
    // main sequence and watchdog
    // ****************************************
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_mcode();
        t_terr();
        t_manual();
        t_start_fend();
        t_skip_stop();
        t_oend();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        print_verdict();
    end
endmodule : tb_motion_program_run_control
